// ==== core/pfsps_params.svh ====
// Purpose: named offsets, field positions and reset values for the
//          pin function select and power state block
// Assumes: 32-bit Avalon-MM data bus, byte addresses
// Notes:   included by its bare name, definitions only
`ifndef PFSPS_PARAMS_SVH
`define PFSPS_PARAMS_SVH

// pin count and bus address width
`define PFSPS_PINS       32
`define PFSPS_AW         8

// register byte offsets
`define PFSPS_OFS_SEL    8'h00
`define PFSPS_OFS_PDEN   8'h04
`define PFSPS_OFS_CTL    8'h08
`define PFSPS_OFS_STAT   8'h0C
`define PFSPS_OFS_RTC    8'h10
`define PFSPS_OFS_MOUT   8'h14
`define PFSPS_OFS_MOE    8'h18
`define PFSPS_OFS_MIN    8'h1C

// reset values of select and power-down enable
`define PFSPS_SEL_RST    32'hF003_0FFC
`define PFSPS_PDEN_RST   32'hFAF0_0000

// select bit positions checked after reset
`define PFSPS_SEL_SIBCLK 12
`define PFSPS_SEL_IR_HI  17
`define PFSPS_SEL_IR_LO  16
`define PFSPS_SEL_CRD_HI 11
`define PFSPS_SEL_CRD_LO 2

// control and status field positions
`define PFSPS_CTL_SLEEP  0
`define PFSPS_ST_VCCON   3
`define PFSPS_ST_PWRDN   4
`define PFSPS_ST_SUPPLY  5
`define PFSPS_ST_FIRST   6

`endif

// ==== core/pfsps_pin_cell.sv ====
// Purpose: one pin's output mux and power-down forcing
// Assumes: all inputs on the same clock, purely combinational
// Notes:   forced pins drive low with the driver released
`timescale 1ns/1ps

module pfsps_pin_cell (
  input  wire logic sel,       // 1 picks the multi-function line
  input  wire logic force_pd,  // pin held in power-down level
  input  wire logic std_out,   // standard function output
  input  wire logic std_oe,    // standard function enable
  input  wire logic mio_out,   // multi-function output
  input  wire logic mio_oe,    // multi-function enable
  output logic      pin_out,   // value toward the pad
  output logic      pin_oe     // driver enable toward the pad
);

  // mux then forcing; forcing wins so a sleeping pad never drives
  always_comb begin
    if (force_pd) begin
      pin_out = 1'b0;
      pin_oe  = 1'b0;
    end else if (sel) begin
      pin_out = mio_out;
      pin_oe  = mio_oe;
    end else begin
      pin_out = std_out;
      pin_oe  = std_oe;
    end
  end

endmodule

// ==== core/pfsps_pkg.sv ====
// Purpose: types shared by the pin function select block
// Assumes: pfsps_params.svh supplies widths
// Notes:   one-hot power state codes
`include "pfsps_params.svh"

package pfsps_pkg;

  // power phases of the device, one-hot
  typedef enum logic [2:0] {
    PFSPS_POR   = 3'h1,
    PFSPS_RUN   = 3'h2,
    PFSPS_SLEEP = 3'h4
  } pfsps_state_t;

  // complete state of the top module
  typedef struct packed {
    pfsps_state_t             state;    // power phase
    logic                     first;    // first running state reached
    logic                     vccon;    // main power enable
    logic [`PFSPS_PINS-1:0]   sel;      // function select
    logic [`PFSPS_PINS-1:0]   pden;     // per-pin power-down enable
    logic [`PFSPS_PINS-1:0]   mout;     // multi-function output value
    logic [`PFSPS_PINS-1:0]   moe;      // multi-function output enable
    logic [`PFSPS_PINS-1:0]   pout;     // registered pin output
    logic [`PFSPS_PINS-1:0]   poe;      // registered pin enable
    logic [`PFSPS_PINS-1:0]   std_in;   // input to standard function
    logic [`PFSPS_PINS-1:0]   mio_in;   // input to multi-function line
    logic [`PFSPS_PINS-1:0]   pin_s1;   // pin synchroniser stage 1
    logic [`PFSPS_PINS-1:0]   pin_s2;   // pin synchroniser stage 2
    logic                     btn_s1;   // on-button stage 1
    logic                     btn_s2;   // on-button stage 2
    logic                     vcc_s1;   // main supply stage 1
    logic                     vcc_s2;   // main supply stage 2
    logic                     pon_s1;   // power-on reset stage 1
    logic                     pon_s2;   // power-on reset stage 2
    logic                     wake_s1;  // wake event stage 1
    logic                     wake_s2;  // wake event stage 2
    logic [31:0]              rtc;      // free-running real-time count
    logic                     waitreq;  // bus waitrequest
    logic [31:0]              rdata;    // bus read data
  } pfsps_regs_t;

endpackage

// ==== core/pfsps_top.sv ====
// Purpose: pin function select and power state sequencing
// Assumes: ref_clk 40 MHz, reset synchronous active high
// Notes:   registers on Avalon-MM slave with waitrequest
//
// Behaviour
// RULE_01: select bit one picks multi-function line
// RULE_02: serial master clock pin defaults standard
// RULE_03: infrared pins default to multi-function
// RULE_04: card interface pins default multi-function
// RULE_05: power-on reset drives pins defined level
// RULE_06: on-button moves reset state to running
// RULE_07: software pin settings survive sleep wake
// RULE_08: clock and wake logic alive asleep
// RULE_09: pin forced down when its condition holds
// RULE_10: powerdown unless main power and supply
// RULE_11: per-pin enable gates global powerdown
// RULE_12: select bits writable, reset, kept asleep
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps

`include "pfsps_params.svh"

module pfsps_top
  import pfsps_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic [`PFSPS_AW-1:0]    avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic [`PFSPS_PINS-1:0]  std_out,
  input  wire logic [`PFSPS_PINS-1:0]  std_oe,
  output logic      [`PFSPS_PINS-1:0]  std_in,
  output logic      [`PFSPS_PINS-1:0]  multi_function_io_line,
  input  wire logic [`PFSPS_PINS-1:0]  pin_in,
  output logic      [`PFSPS_PINS-1:0]  pin_out,
  output logic      [`PFSPS_PINS-1:0]  pin_oe,
  input  wire logic                    power_on_reset_n,
  input  wire logic                    on_button_in,
  input  wire logic                    main_supply_present,
  input  wire logic                    wake_event_in,
  output logic                         main_power_enable,
  output logic      [2:0]              power_state
);

  // reset image of the whole state
  // RULE_02 RULE_03 RULE_04: select defaults here
  localparam pfsps_regs_t RST = '{
    state: PFSPS_POR, first: 1'b0, vccon: 1'b0,
    sel: `PFSPS_SEL_RST, pden: `PFSPS_PDEN_RST,
    mout: '0, moe: '0, pout: '0, poe: '0, std_in: '0, mio_in: '0,
    pin_s1: '0, pin_s2: '0, btn_s1: 1'b0, btn_s2: 1'b0,
    vcc_s1: 1'b0, vcc_s2: 1'b0, pon_s1: 1'b1, pon_s2: 1'b1,
    wake_s1: 1'b0, wake_s2: 1'b0, rtc: '0,
    waitreq: 1'b1, rdata: '0};

  pfsps_regs_t            st;            // registered state
  pfsps_regs_t            next_st;       // next state
  logic                   global_pd;     // global power-down condition
  logic [`PFSPS_PINS-1:0] force_vec;     // per-pin forcing
  logic [`PFSPS_PINS-1:0] cell_out;      // mux result per pin
  logic [`PFSPS_PINS-1:0] cell_oe;       // mux enable per pin
  logic [31:0]            status_word;   // status register image
  logic                   bus_wr;        // write takes effect now
  logic                   sw_ok;         // software may reprogram

  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // RULE_10: powerdown from power enable and supply
  assign global_pd = ~(st.vccon & st.vcc_s2);

  // RULE_09: forcing decided per pin
  // RULE_11: per-pin enable gates powerdown
  // RULE_05: reset phase forces every pin
  assign force_vec = ({`PFSPS_PINS{global_pd}} & st.pden) |
                     {`PFSPS_PINS{st.state == PFSPS_POR}};

  // software only runs with main power up
  assign sw_ok  = (st.state == PFSPS_RUN);
  assign bus_wr = avs_write & ~st.waitreq;

  assign status_word = {25'h000_0000, st.first, st.vcc_s2, global_pd,
                        st.vccon, st.state};

  // per-pin output mux cells
  for (genvar i = 0; i < `PFSPS_PINS; i++) begin : g_pin
    // RULE_01: select between two sources
    pfsps_pin_cell u_cell (
      .sel      (st.sel[i]),
      .force_pd (force_vec[i]),
      .std_out  (std_out[i]),
      .std_oe   (std_oe[i]),
      .mio_out  (st.mout[i]),
      .mio_oe   (st.moe[i]),
      .pin_out  (cell_out[i]),
      .pin_oe   (cell_oe[i])
    );
  end

  // next-state logic for sync, phases, pins and bus
  always_comb begin
    next_st = st;
    // two-stage synchronisers for pins and outside levels
    next_st.pin_s1  = pin_in;
    next_st.pin_s2  = st.pin_s1;
    next_st.btn_s1  = on_button_in;
    next_st.btn_s2  = st.btn_s1;
    next_st.vcc_s1  = main_supply_present;
    next_st.vcc_s2  = st.vcc_s1;
    next_st.pon_s1  = power_on_reset_n;
    next_st.pon_s2  = st.pon_s1;
    next_st.wake_s1 = wake_event_in;
    next_st.wake_s2 = st.wake_s1;
    // RULE_08: count runs in every phase
    next_st.rtc = st.rtc + 32'h0000_0001;
    // RULE_01: inputs routed by select bit
    next_st.std_in = st.pin_s2 & ~st.sel;
    next_st.mio_in = st.pin_s2 & st.sel;
    next_st.pout   = cell_out;
    next_st.poe    = cell_oe;
    // bus handshake, one wait cycle per access
    next_st.waitreq = ~((avs_read | avs_write) & st.waitreq);
    if (avs_read & st.waitreq) begin
      unique case (avs_address)
        `PFSPS_OFS_SEL:  next_st.rdata = st.sel;
        `PFSPS_OFS_PDEN: next_st.rdata = st.pden;
        `PFSPS_OFS_STAT: next_st.rdata = status_word;
        `PFSPS_OFS_RTC:  next_st.rdata = st.rtc;
        `PFSPS_OFS_MOUT: next_st.rdata = st.mout;
        `PFSPS_OFS_MOE:  next_st.rdata = st.moe;
        `PFSPS_OFS_MIN:  next_st.rdata = st.mio_in;
        // control reads zero, unmapped reads zero
        default:         next_st.rdata = 32'h0000_0000;
      endcase
    end
    // RULE_07: reprogramming only while running
    // RULE_12: select bits are writable storage
    if (bus_wr & sw_ok) begin
      unique case (avs_address)
        `PFSPS_OFS_SEL:  next_st.sel  = merge(st.sel, avs_writedata,
                                              avs_byteenable);
        `PFSPS_OFS_PDEN: next_st.pden = merge(st.pden, avs_writedata,
                                              avs_byteenable);
        `PFSPS_OFS_MOUT: next_st.mout = merge(st.mout, avs_writedata,
                                              avs_byteenable);
        `PFSPS_OFS_MOE:  next_st.moe  = merge(st.moe, avs_writedata,
                                              avs_byteenable);
        // unmapped and read-only writes are dropped
        default: ;
      endcase
    end
    // power phase sequencing
    unique case (st.state)
      // RULE_06: on-button leaves reset phase
      PFSPS_POR: begin
        if (st.btn_s2) begin
          next_st.state = PFSPS_RUN;
          next_st.first = 1'b1;
        end
      end
      // sleep only on software request
      PFSPS_RUN: begin
        if (bus_wr & (avs_address == `PFSPS_OFS_CTL) & avs_byteenable[0]
            & avs_writedata[`PFSPS_CTL_SLEEP]) begin
          next_st.state = PFSPS_SLEEP;
        end
      end
      // RULE_08: wake logic alive in sleep
      PFSPS_SLEEP: begin
        if (st.btn_s2 | st.wake_s2) begin
          next_st.state = PFSPS_RUN;
        end
      end
    endcase
    // RULE_05: reset pin restores power-on image
    if (!st.pon_s2) begin
      next_st.state = PFSPS_POR;
      next_st.first = 1'b0;
      next_st.sel   = `PFSPS_SEL_RST;
      next_st.pden  = `PFSPS_PDEN_RST;
      next_st.mout  = '0;
      next_st.moe   = '0;
    end
    next_st.vccon = (next_st.state == PFSPS_RUN);
  end

  // single state register, constant on reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign avs_readdata           = st.rdata;
  assign avs_waitrequest        = st.waitreq;
  assign std_in                 = st.std_in;
  assign multi_function_io_line = st.mio_in;
  assign pin_out                = st.pout;
  assign pin_oe                 = st.poe;
  assign main_power_enable      = st.vccon;
  assign power_state            = st.state;

  // reference mux for output checking
  logic [`PFSPS_PINS-1:0] mux_ref;   // expected unforced output
  assign mux_ref = (st.sel & st.mout) | (~st.sel & std_out);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence por_press;
    st.state == PFSPS_POR && st.btn_s2 && st.pon_s2;
  endsequence

  sequence sleep_wake;
    st.state == PFSPS_SLEEP ##1 st.state == PFSPS_RUN;
  endsequence

  sel_mux_out_a: assert property ( // RULE_01
    ((pin_out ^ $past(mux_ref)) & ~$past(force_vec)) == '0)
    else $error("pin output does not follow select");

  sibclk_default_a: assert property (disable iff (1'b0) // RULE_02
    reset |=> !st.sel[`PFSPS_SEL_SIBCLK])
    else $error("serial clock select not cleared by reset");

  ir_default_a: assert property (disable iff (1'b0) // RULE_03
    reset |=> &st.sel[`PFSPS_SEL_IR_HI:`PFSPS_SEL_IR_LO])
    else $error("infrared selects not set by reset");

  card_default_a: assert property (disable iff (1'b0) // RULE_04
    reset |=> &st.sel[`PFSPS_SEL_CRD_HI:`PFSPS_SEL_CRD_LO])
    else $error("card selects not set by reset");

  pon_entry_a: assert property ( // RULE_05
    !power_on_reset_n |-> ##3 (st.state == PFSPS_POR) ##1 (pin_oe == '0))
    else $error("reset pin did not force reset phase");

  button_run_a: assert property ( // RULE_06
    por_press |=> (st.state == PFSPS_RUN && main_power_enable))
    else $error("on-button did not start running phase");

  wake_keep_a: assert property ( // RULE_07
    sleep_wake |-> $stable(st.sel) && $stable(st.pden))
    else $error("pin settings lost across wake");

  rtc_alive_a: assert property ( // RULE_08
    st.state == PFSPS_SLEEP |=> st.rtc == $past(st.rtc) + 32'h0000_0001)
    else $error("real-time count stopped in sleep");

  pd_release_a: assert property ( // RULE_09
    (pin_oe & $past(force_vec)) == '0)
    else $error("forced pin still driven");

  pd_global_a: assert property ( // RULE_10
    st.state == PFSPS_POR |-> global_pd && !main_power_enable)
    else $error("powerdown inactive in reset phase");

  pd_gate_a: assert property ( // RULE_11
    st.state == PFSPS_SLEEP |-> force_vec == st.pden)
    else $error("per-pin enable not gating powerdown");

  sel_hold_a: assert property ( // RULE_12
    st.state == PFSPS_SLEEP && st.pon_s2 |=> $stable(st.sel))
    else $error("select bits changed during sleep");

endmodule

// ==== verif/pfsps_tb_top.sv ====
// Purpose: self-checking bench for the pin select and power state block
// Assumes: ref_clk 25 ns, reset synchronous active high
// Notes:   expected values come from bench-side model words
`timescale 1ns/1ps
`include "pfsps_params.svh"

module pfsps_tb_top;
  logic        ref_clk             = 1'b0;  // system clock
  logic        reset               = 1'b1;  // sync, active high
  logic [7:0]  avs_address         = 8'h00; // bus address
  logic        avs_read            = 1'b0;  // bus read
  logic        avs_write           = 1'b0;  // bus write
  logic [31:0] avs_writedata       = 32'h0000_0000;
  logic [3:0]  avs_byteenable      = 4'hF;  // write lanes
  logic [31:0] avs_readdata;                // read data
  logic        avs_waitrequest;             // bus stall
  logic [31:0] std_out             = 32'h0000_0000;
  logic [31:0] std_oe              = 32'h0000_0000;
  logic [31:0] pin_in              = 32'h0000_0000;
  logic [31:0] std_in;                      // pad to standard side
  logic [31:0] mio_line;                    // pad to multi side
  logic [31:0] pin_out;                     // pad value
  logic [31:0] pin_oe;                      // pad enable
  logic        power_on_reset_n    = 1'b1;  // active low
  logic        on_button_in        = 1'b0;  // start button
  logic        main_supply_present = 1'b1;  // supply sense
  logic        wake_event_in       = 1'b0;  // wake request
  logic        main_power_enable;           // running flag
  logic [2:0]  power_state;                 // one-hot phase
  logic [31:0] sel_m;                       // model of select
  logic [31:0] pden_m;                      // model of pd enable
  logic [31:0] mout_m;                      // model of mio output
  logic [31:0] moe_m;                       // model of mio enable
  logic [31:0] rd;                          // last read word
  logic [31:0] t;                           // scratch word
  int          n_errors            = 0;
  int          checks              = 0;

  // free-running clock
  always #12.5 ref_clk = ~ref_clk;

  pfsps_top pfsps_top_i (
    .ref_clk                (ref_clk),
    .reset                  (reset),
    .avs_address            (avs_address),
    .avs_read               (avs_read),
    .avs_write              (avs_write),
    .avs_writedata          (avs_writedata),
    .avs_byteenable         (avs_byteenable),
    .avs_readdata           (avs_readdata),
    .avs_waitrequest        (avs_waitrequest),
    .std_out                (std_out),
    .std_oe                 (std_oe),
    .std_in                 (std_in),
    .multi_function_io_line (mio_line),
    .pin_in                 (pin_in),
    .pin_out                (pin_out),
    .pin_oe                 (pin_oe),
    .power_on_reset_n       (power_on_reset_n),
    .on_button_in           (on_button_in),
    .main_supply_present    (main_supply_present),
    .wake_event_in          (wake_event_in),
    .main_power_enable      (main_power_enable),
    .power_state            (power_state)
  );

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int i;
    @(posedge ref_clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= d;
    avs_byteenable <= be;
    for (i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    // a stuck slave ends the run
    if (i == 16) begin
      n_errors++;
      complete_run();
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // read and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(rd, exp);
  endtask

  // bounded wait for a power phase
  task automatic wait_state(input logic [2:0] s);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (power_state === s) break;
    end
    if (i == 40) begin
      n_errors++;
      complete_run();
    end
  endtask

  // steady-state pad check; pd marks global power-down active
  task automatic pin_chk(input logic pd);
    logic [31:0] f;
    logic [31:0] eo;
    logic [31:0] ee;
    repeat (6) @(posedge ref_clk);
    f  = pd ? pden_m : 32'h0000_0000;
    eo = ~f & ((sel_m & mout_m) | (~sel_m & std_out));
    ee = ~f & ((sel_m & moe_m) | (~sel_m & std_oe));
    chk(pin_out, eo);
    chk(pin_oe, ee);
    chk(std_in, pin_in & ~sel_m);
    chk(mio_line, pin_in & sel_m);
  endtask

  // hang guard
  initial begin
    #(25 * 20000);
    n_errors++;
    complete_run();
  end

  // main sequence
  initial begin
    void'($urandom(32'h1603));
    repeat (12) @(posedge ref_clk);
    reset  <= 1'b0;
    sel_m  = `PFSPS_SEL_RST;
    pden_m = `PFSPS_PDEN_RST;
    mout_m = 32'h0000_0000;
    moe_m  = 32'h0000_0000;
    @(posedge ref_clk);
    chk({29'h0, power_state}, 32'h0000_0001);
    chk(pin_oe, 32'h0000_0000);
    rdchk(`PFSPS_OFS_SEL, `PFSPS_SEL_RST);
    rdchk(`PFSPS_OFS_PDEN, `PFSPS_PDEN_RST);
    // writes before the first run are dropped
    bus(1'b1, `PFSPS_OFS_SEL, 32'h0000_0000, 4'hF);
    rdchk(`PFSPS_OFS_SEL, `PFSPS_SEL_RST);
    rdchk(`PFSPS_OFS_STAT, 32'h0000_0031);
    on_button_in <= 1'b1;
    wait_state(3'h2);
    on_button_in <= 1'b0;
    chk({31'h0, main_power_enable}, 32'h0000_0001);
    rdchk(`PFSPS_OFS_STAT, 32'h0000_006A);
    pden_m = $urandom();
    bus(1'b1, `PFSPS_OFS_PDEN, pden_m, 4'hF);
    // random pad traffic through both functions
    for (int k = 0; k < 4; k++) begin
      sel_m  = $urandom();
      mout_m = $urandom();
      moe_m  = $urandom();
      std_out <= $urandom();
      std_oe  <= $urandom();
      pin_in  <= $urandom();
      bus(1'b1, `PFSPS_OFS_SEL, sel_m, 4'hF);
      bus(1'b1, `PFSPS_OFS_MOUT, mout_m, 4'hF);
      bus(1'b1, `PFSPS_OFS_MOE, moe_m, 4'hF);
      rdchk(`PFSPS_OFS_SEL, sel_m);
      pin_chk(1'b0);
      rdchk(`PFSPS_OFS_MOUT, mout_m);
      rdchk(`PFSPS_OFS_MOE, moe_m);
      rdchk(`PFSPS_OFS_MIN, pin_in & sel_m);
    end
    // control place reads back as zero
    rdchk(`PFSPS_OFS_CTL, 32'h0000_0000);
    // lane merge, then an unmapped place
    bus(1'b1, `PFSPS_OFS_SEL, 32'h0000_0000, 4'h1);
    sel_m = {sel_m[31:8], 8'h00};
    rdchk(`PFSPS_OFS_SEL, sel_m);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
    rdchk(8'h40, 32'h0000_0000);
    // supply loss forces the enabled pins only
    main_supply_present <= 1'b0;
    pin_chk(1'b1);
    rdchk(`PFSPS_OFS_STAT, 32'h0000_005A);
    main_supply_present <= 1'b1;
    pin_chk(1'b0);
    // sleep: clock keeps counting, writes dropped
    bus(1'b1, `PFSPS_OFS_CTL, 32'h0000_0001, 4'hF);
    wait_state(3'h4);
    chk({31'h0, main_power_enable}, 32'h0000_0000);
    pin_chk(1'b1);
    bus(1'b0, `PFSPS_OFS_RTC, 32'h0000_0000, 4'hF);
    t = rd;
    bus(1'b0, `PFSPS_OFS_RTC, 32'h0000_0000, 4'hF);
    chk(rd - t, 32'h0000_0003);
    bus(1'b1, `PFSPS_OFS_SEL, 32'h0000_0000, 4'hF);
    wake_event_in <= 1'b1;
    wait_state(3'h2);
    wake_event_in <= 1'b0;
    rdchk(`PFSPS_OFS_SEL, sel_m);
    pin_chk(1'b0);
    // second sleep, woken by the on-button this time
    bus(1'b1, `PFSPS_OFS_CTL, 32'h0000_0001, 4'hF);
    wait_state(3'h4);
    on_button_in <= 1'b1;
    wait_state(3'h2);
    on_button_in <= 1'b0;
    rdchk(`PFSPS_OFS_PDEN, pden_m);
    pin_chk(1'b0);
    // power-on reset pin restores defaults
    power_on_reset_n <= 1'b0;
    wait_state(3'h1);
    power_on_reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(pin_oe, 32'h0000_0000);
    chk(pin_out, 32'h0000_0000);
    rdchk(`PFSPS_OFS_SEL, `PFSPS_SEL_RST);
    rdchk(`PFSPS_OFS_PDEN, `PFSPS_PDEN_RST);
    rdchk(`PFSPS_OFS_MOUT, 32'h0000_0000);
    rdchk(`PFSPS_OFS_STAT, 32'h0000_0031);
    complete_run();
  end
endmodule
